// ### include/aii_defs.svh
// Functional notes
// - Mode 0: read pair loads result 9:6 to aux, 5:2 to accumulator.
// - Mode 1: read pair loads result 7:4 to aux, 3:0 to accumulator.
// - Low-bits read: result 1:0 to accumulator 3:2, accumulator 1:0 cleared.
// - Comparator mode: write compare value takes aux to 7:4, accumulator to 3:0.
// - Mode 0: write compare value is a no-operation.
// - Control register read to and written from accumulator; bit 3 selects mode.
// - Start clears done flag; in mode 0 it begins a conversion.
// - Start in mode 1 begins a comparator operation and clears done flag on the same clock edge.
// - Start decodes from opcode 0x29F, one word, one cycle.
// - Irq enable 0: skip-on-done skips when flag set, then clears flag.
// - Irq enable 1: skip-on-done is no-operation, flag unchanged.
`ifndef AII_DEFS_SVH
`define AII_DEFS_SVH
`define AII_OP_START       10'h29F
`define AII_MODE_BIT       3
`define AII_CONV_CYCLES    8'h10
`define AII_CTRL_RESET     4'h0
`define AII_ADDR_CTRL      12'h000
`define AII_ADDR_RESULT    12'h004
`define AII_ADDR_STATUS    12'h008
`define AII_ADDR_IRQ_EN    12'h00C
`define AII_ADDR_IRQ_CLR   12'h010
`define AII_ADDR_CMP       12'h014
`define AII_ADDR_CMP_IN    12'h018
`endif

// ### include/aii_pkg.sv
package aii_pkg;
  typedef enum logic [3:0] {
    AII_INS_NONE   = 4'h0,
    AII_INS_RDPAIR = 4'h1,
    AII_INS_RDLOW  = 4'h2,
    AII_INS_WRCMP  = 4'h3,
    AII_INS_RDCTRL = 4'h4,
    AII_INS_WRCTRL = 4'h5,
    AII_INS_START  = 4'h6,
    AII_INS_SKIP   = 4'h7
  } aii_instr_type;
  typedef enum logic [2:0] {
    AII_IDLE = 3'b001,
    AII_CONV = 3'b010,
    AII_CMP  = 3'b100
  } aii_state_type;
endpackage

// ### rtl/aii_converter.sv
`include "aii_defs.svh"
module aii_converter (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       cmp_mode,
  input  wire logic [9:0] sample,
  input  wire logic [7:0] cmp_value,
  output logic [9:0]      result,
  output logic            cmp_out,
  output logic            busy,
  output logic            done
);
  import aii_pkg::*;
  aii_state_type state_reg;
  logic [7:0]    cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= AII_IDLE;
      cnt_reg   <= 8'h00;
    end else if (start) begin
      state_reg <= cmp_mode ? AII_CMP : AII_CONV;
      cnt_reg   <= `AII_CONV_CYCLES;
    end else begin
      case (state_reg)
        AII_CONV, AII_CMP: begin
          if (cnt_reg == 8'h01) begin
            state_reg <= AII_IDLE;
          end
          cnt_reg <= cnt_reg - 8'h01;
        end
        default: state_reg <= AII_IDLE;
      endcase
    end
  end

  wire finish = (state_reg != AII_IDLE) && (cnt_reg == 8'h01) && !start;
  assign busy = (state_reg != AII_IDLE);
  assign done = finish;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result  <= 10'h000;
      cmp_out <= 1'b0;
    end else if (finish && state_reg == AII_CONV) begin
      result <= sample;
    end else if (finish) begin
      cmp_out <= (sample[9:2] >= cmp_value);
    end
  end

  conv_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> busy [*8]) else $error("Converter busy too short");
endmodule

// ### rtl/aii_top.sv
`include "aii_defs.svh"
module aii_top (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [9:0]             opcode,
  input  wire logic                   opcode_valid,
  input  wire aii_pkg::aii_instr_type instr,
  input  wire logic [3:0]             acc_in,
  input  wire logic [3:0]             aux_in,
  input  wire logic                   conv_irq_enable,
  input  wire logic [9:0]             analog_sample,
  output logic                        acc_we,
  output logic [3:0]                  acc_out,
  output logic                        aux_we,
  output logic [3:0]                  aux_out,
  output logic                        skip_next,
  output logic                        comparator_out,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq
);
  import aii_pkg::*;

  logic [3:0] conv_ctrl_reg;
  logic       conv_done_flag;
  logic [7:0] cmp_reg;
  logic [1:0] status_reg;
  logic [1:0] irq_en_reg;
  logic [9:0] result;
  logic       cmp_res;
  logic       busy;
  logic       done;
  logic [9:0] samp_s1_reg;
  logic [9:0] samp_s2_reg;

  wire mode_select_bit   = conv_ctrl_reg[`AII_MODE_BIT];
  wire start_conv_instr  = opcode_valid && (opcode == `AII_OP_START);
  wire skip_on_conv_done = (instr == AII_INS_SKIP);
  wire skip_take         = skip_on_conv_done && !conv_irq_enable && conv_done_flag;
  wire apb_wr            = psel && penable && pwrite;
  wire apb_rd_unmapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_s1_reg <= 10'h000;
      samp_s2_reg <= 10'h000;
    end else begin
      samp_s1_reg <= analog_sample;
      samp_s2_reg <= samp_s1_reg;
    end
  end

  aii_converter u_conv (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (start_conv_instr),
    .cmp_mode  (mode_select_bit),
    .sample    (samp_s2_reg),
    .cmp_value (cmp_reg),
    .result    (result),
    .cmp_out   (cmp_res),
    .busy      (busy),
    .done      (done)
  );
  assign comparator_out = cmp_res;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ctrl_reg <= `AII_CTRL_RESET;
    end else if (instr == AII_INS_WRCTRL) begin
      conv_ctrl_reg <= acc_in;
    end else if (apb_wr && paddr == `AII_ADDR_CTRL) begin
      conv_ctrl_reg <= pwdata[3:0];
    end
  end

  // Compare value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_reg <= 8'h00;
    end else if (instr == AII_INS_WRCMP && mode_select_bit) begin
      cmp_reg <= {aux_in, acc_in};
    end else if (apb_wr && paddr == `AII_ADDR_CMP && mode_select_bit) begin
      cmp_reg <= pwdata[7:0];
    end
  end

  // Done flag: finish wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_flag <= 1'b0;
    end else if (done) begin
      conv_done_flag <= 1'b1;
    end else if (start_conv_instr) begin
      conv_done_flag <= 1'b0;
    end else if (skip_take) begin
      conv_done_flag <= 1'b0;
    end
  end

  // Accumulator and aux outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_out <= 4'h0;
      aux_out <= 4'h0;
      acc_we  <= 1'b0;
      aux_we  <= 1'b0;
    end else begin
      acc_we <= 1'b0;
      aux_we <= 1'b0;
      case (instr)
        AII_INS_RDPAIR: begin
          acc_we <= 1'b1;
          aux_we <= 1'b1;
          if (mode_select_bit) begin
            aux_out <= result[7:4];
            acc_out <= result[3:0];
          end else begin
            aux_out <= result[9:6];
            acc_out <= result[5:2];
          end
        end
        AII_INS_RDLOW: begin
          acc_we  <= 1'b1;
          acc_out <= {result[1:0], 2'b00};
        end
        AII_INS_RDCTRL: begin
          acc_we  <= 1'b1;
          acc_out <= conv_ctrl_reg;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_next <= 1'b0;
    end else begin
      skip_next <= skip_take;
    end
  end

  // Interrupt status: bit0 done, bit1 comparator finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (done && (i == 0 || mode_select_bit)) begin
          status_reg[i] <= 1'b1;
        end else if (apb_wr && paddr == `AII_ADDR_IRQ_CLR && pwdata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= 2'b00;
    end else if (apb_wr && paddr == `AII_ADDR_IRQ_EN) begin
      irq_en_reg <= pwdata[1:0];
    end
  end
  assign irq = |(status_reg & irq_en_reg);

  // APB read side
  assign pready = 1'b1;
  assign apb_rd_unmapped = !(paddr == `AII_ADDR_CTRL || paddr == `AII_ADDR_RESULT ||
                             paddr == `AII_ADDR_STATUS || paddr == `AII_ADDR_IRQ_EN ||
                             paddr == `AII_ADDR_IRQ_CLR || paddr == `AII_ADDR_CMP ||
                             paddr == `AII_ADDR_CMP_IN);
  assign pslverr = psel && penable && apb_rd_unmapped;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `AII_ADDR_CTRL:   prdata = {28'h000_0000, conv_ctrl_reg};
      `AII_ADDR_RESULT: prdata = {22'h00_0000, result};
      `AII_ADDR_STATUS: prdata = {28'h000_0000, busy, cmp_res, status_reg};
      `AII_ADDR_IRQ_EN: prdata = {30'h0000_0000, irq_en_reg};
      `AII_ADDR_CMP:    prdata = {24'h00_0000, cmp_reg};
      `AII_ADDR_CMP_IN: prdata = {31'h0000_0000, conv_done_flag};
      default:          prdata = 32'h0000_0000;
    endcase
  end

  // Checks
  sequence start_seq;
    start_conv_instr && !done;
  endsequence

  sequence rd_pair_seq;
    instr == AII_INS_RDPAIR;
  endsequence

  sequence skip_idle_seq;
    skip_on_conv_done && conv_irq_enable && !start_conv_instr && !done;
  endsequence

  sequence finish_seq;
    done ##1 !busy;
  endsequence

  start_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_seq |=> !conv_done_flag)
    else $error("Start left done flag set");

  start_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_conv_instr |=> busy)
    else $error("Start did not begin operation");

  pair_m0_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_pair_seq ##0 !mode_select_bit) |=>
      (aux_out == $past(result[9:6]) && acc_out == $past(result[5:2]) && acc_we))
    else $error("Mode 0 pair read wrong");

  pair_m1_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_pair_seq ##0 mode_select_bit) |=>
      (aux_out == $past(result[7:4]) && acc_out == $past(result[3:0])))
    else $error("Mode 1 pair read wrong");

  low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    instr == AII_INS_RDLOW |=> acc_out == {$past(result[1:0]), 2'b00})
    else $error("Low bits read wrong");

  cmp_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (instr == AII_INS_WRCMP && mode_select_bit) |=>
      cmp_reg == {$past(aux_in), $past(acc_in)})
    else $error("Compare write wrong");

  cmp_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (instr == AII_INS_WRCMP && !mode_select_bit && !apb_wr) |=> $stable(cmp_reg))
    else $error("Compare write in mode 0");

  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    instr == AII_INS_WRCTRL |=> conv_ctrl_reg == $past(acc_in))
    else $error("Control write wrong");

  skip_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    (skip_on_conv_done && !conv_irq_enable && conv_done_flag && !done) |=>
      (skip_next && !conv_done_flag))
    else $error("Skip not taken");

  skip_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    skip_idle_seq |=> (!skip_next && conv_done_flag == $past(conv_done_flag)))
    else $error("Skip acted with irq enabled");

  done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> conv_done_flag)
    else $error("Done flag not set");

  finish_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> ##[0:1] conv_done_flag)
    else $error("Finish lost");

  op_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(opcode_valid && opcode == `AII_OP_START) && !busy) |=> !busy)
    else $error("Converter started without start opcode");

  busy_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> $past(opcode_valid && opcode == `AII_OP_START))
    else $error("Busy rose without start opcode");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!done && !start_conv_instr && !(skip_on_conv_done && !conv_irq_enable)) |=>
      $stable(conv_done_flag))
    else $error("Done flag changed without cause");

  irq_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_irq_enable && !done && !start_conv_instr) |=> $stable(conv_done_flag))
    else $error("Done flag cleared with irq enabled");

  skip_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    skip_next |-> $past(skip_on_conv_done && conv_done_flag && !conv_irq_enable))
    else $error("Skip without set flag");

  skip_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_irq_enable |=> !skip_next)
    else $error("Skip with irq enabled");

  skip_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (skip_on_conv_done && !conv_done_flag) |=> !skip_next)
    else $error("Skip with clear flag");

  result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !done |=> $stable(result))
    else $error("Result changed without finish");

  cmp_res_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !done |=> $stable(cmp_res))
    else $error("Comparator result changed without finish");

  busy_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> $past(done))
    else $error("Busy fell without finish");

  done_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> busy)
    else $error("Finish while idle");

  fin_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> finish_seq)
    else $error("Converter busy after finish");

  status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> status_reg[0])
    else $error("Finish status not set");

  ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (instr != AII_INS_WRCTRL && !(apb_wr && paddr == `AII_ADDR_CTRL)) |=>
      $stable(conv_ctrl_reg))
    else $error("Control register changed without write");

  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    instr == AII_INS_RDCTRL |=> (acc_we && !aux_we && acc_out == $past(conv_ctrl_reg)))
    else $error("Control read wrong");

  low_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    instr == AII_INS_RDLOW |=> (acc_we && !aux_we && acc_out[1:0] == 2'b00))
    else $error("Low bits read left bits set");

  pair_we_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_pair_seq |=> (acc_we && aux_we))
    else $error("Pair read without both writes");

  aux_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    instr != AII_INS_RDPAIR |=> !aux_we)
    else $error("Aux write without pair read");

  acc_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(instr inside {AII_INS_RDPAIR, AII_INS_RDLOW, AII_INS_RDCTRL}) |=> !acc_we)
    else $error("Accumulator write without read");

  cmp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(instr == AII_INS_WRCMP && mode_select_bit) &&
      !(apb_wr && paddr == `AII_ADDR_CMP)) |=> $stable(cmp_reg))
    else $error("Compare value changed without write");

  irq_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> (status_reg != 2'b00))
    else $error("Interrupt without status");

  ctrl_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr == `AII_ADDR_CTRL) |-> (pready && !pslverr))
    else $error("Control access refused");
endmodule

// ### verif/aii_core_model.sv
module aii_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       acc_we,
  input  wire logic [3:0] acc_out,
  input  wire logic       aux_we,
  input  wire logic [3:0] aux_out,
  input  wire logic       skip_next,
  output logic [3:0]      acc_reg,
  output logic [3:0]      aux_reg,
  output logic [7:0]      skip_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  // Acc and aux registers loaded only on write pulses; skip count bumped on skip pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg  <= 4'h0;
      aux_reg  <= 4'h0;
      skip_reg <= 8'h00;
    end else begin
      if (acc_we) acc_reg <= acc_out;
      if (aux_we) aux_reg <= aux_out;
      if (skip_next) skip_reg <= skip_reg + 8'h01;
    end
  end
endmodule

// ### verif/adc_instruction_interface_bench.sv
`include "aii_defs.svh"
module adc_instruction_interface_bench import aii_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic [9:0]    opcode = 10'h000;
  logic          opcode_valid = 1'b0;
  aii_instr_type instr = AII_INS_NONE;
  logic [3:0]    acc_in = 4'h0;
  logic [3:0]    aux_in = 4'h0;
  logic          conv_irq_enable = 1'b0;
  logic [9:0]    analog_sample = 10'h2D6;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0000_0000;
  logic          acc_we, aux_we, skip_next, comparator_out, pready, pslverr, irq;
  logic [3:0]    acc_out, aux_out, acc_reg, aux_reg;
  logic [7:0]    skip_reg;
  logic [31:0]   prdata, rd;
  logic          err;
  int            err_count = 0;
  int            comparisons = 0;

  always #5 pclk = ~pclk;

  aii_top dut_u (.pclk(pclk), .presetn(presetn), .opcode(opcode),
    .opcode_valid(opcode_valid), .instr(instr), .acc_in(acc_in), .aux_in(aux_in),
    .conv_irq_enable(conv_irq_enable), .analog_sample(analog_sample),
    .acc_we(acc_we), .acc_out(acc_out), .aux_we(aux_we), .aux_out(aux_out),
    .skip_next(skip_next), .comparator_out(comparator_out), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  aii_core_model core_u (.pclk(pclk), .presetn(presetn), .acc_we(acc_we),
    .acc_out(acc_out), .aux_we(aux_we), .aux_out(aux_out), .skip_next(skip_next),
    .acc_reg(acc_reg), .aux_reg(aux_reg), .skip_reg(skip_reg));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      disable run_all;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic ins(input aii_instr_type i, input logic [3:0] a, input logic [3:0] b);
    @(posedge pclk);
    instr  <= i;
    acc_in <= a;
    aux_in <= b;
    @(posedge pclk);
    instr <= AII_INS_NONE;
    @(posedge pclk);
    #1;
  endtask

  task automatic op(input logic [9:0] o);
    @(posedge pclk);
    opcode       <= o;
    opcode_valid <= 1'b1;
    @(posedge pclk);
    opcode_valid <= 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, `AII_ADDR_CMP_IN, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b1 && n < 40);
    if (rd[0] !== 1'b1) begin
      err_count++;
      disable run_all;
    end
  endtask

  task automatic run_all;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    op(`AII_OP_START);
    wait_done();
    check(32'(rd[0]), 32'h0000_0001);
    apb(1'b0, `AII_ADDR_RESULT, 32'h0000_0000);
    check(rd, 32'h0000_02D6);
    apb(1'b0, `AII_ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    ins(AII_INS_RDPAIR, 4'h0, 4'h0);
    check(32'({aux_reg, acc_reg}), 32'h0000_00B5);
    ins(AII_INS_RDLOW, 4'h0, 4'h0);
    check(32'(acc_reg), 32'h0000_0008);
    ins(AII_INS_WRCMP, 4'h3, 4'h3);
    apb(1'b0, `AII_ADDR_CMP, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("conversion test done");
    apb(1'b1, `AII_ADDR_IRQ_EN, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    apb(1'b1, `AII_ADDR_IRQ_CLR, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    @(posedge pclk);
    conv_irq_enable <= 1'b1;
    ins(AII_INS_SKIP, 4'h0, 4'h0);
    apb(1'b0, `AII_ADDR_CMP_IN, 32'h0000_0000);
    check(32'({skip_reg, rd[0]}), 32'h0000_0001);
    conv_irq_enable <= 1'b0;
    ins(AII_INS_SKIP, 4'h0, 4'h0);
    apb(1'b0, `AII_ADDR_CMP_IN, 32'h0000_0000);
    check(32'({skip_reg, rd[0]}), 32'h0000_0002);
    $display("skip and interrupt test done");
    ins(AII_INS_WRCTRL, 4'h8, 4'h0);
    ins(AII_INS_RDCTRL, 4'h0, 4'h0);
    check(32'(acc_reg), 32'h0000_0008);
    ins(AII_INS_RDPAIR, 4'h0, 4'h0);
    check(32'({aux_reg, acc_reg}), 32'h0000_00D6);
    ins(AII_INS_WRCMP, 4'h5, 4'hA);
    apb(1'b0, `AII_ADDR_CMP, 32'h0000_0000);
    check(rd, 32'h0000_00A5);
    op(`AII_OP_START);
    wait_done();
    check(32'(comparator_out), 32'h0000_0001);
    op(10'h29E);
    apb(1'b0, `AII_ADDR_CMP_IN, 32'h0000_0000);
    check(32'(rd[0]), 32'h0000_0001);
    op(`AII_OP_START);
    apb(1'b0, `AII_ADDR_CMP_IN, 32'h0000_0000);
    check(32'(rd[0]), 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    $display("comparator test done");
  endtask

  initial begin
    run_all();
    summarize();
  end
endmodule
